// *** qpdbi_buf.sv ***
/*
  Shared constants and helpers for the quad-pumped data path, and the
  small word buffer that sits in front of the transmitter.
  Assumes one core clock, a synchronous active-low reset and a clock
  enable that freezes all state while low.
*/
package qpdbi_pkg;
  // Bus geometry
  localparam int DATA_W = 64;
  localparam int LANES = 4;
  localparam int LANE_W = 16;
  localparam int BEATS = 4;
  localparam int WORD_W = DATA_W * BEATS;
  localparam int LANE_HALF = LANE_W / 2;
  localparam int ONES_W = $clog2(LANE_W + 1);
  localparam int BEAT_W = $clog2(BEATS);
  // Timing: core clock and bus clock, in ns
  localparam int CORE_PERIOD_NS = 10;
  localparam int BUS_PERIOD_NS = 160;
  localparam int BUS_CYC = BUS_PERIOD_NS / CORE_PERIOD_NS;
  localparam int BEAT_CYC = BUS_CYC / BEATS;
  localparam int STROBE_PHASE = BEAT_CYC / 2;
  localparam int CNT_W = $clog2(BUS_CYC);
  // Buffer depth and idle levels after reset
  localparam int BUF_DEPTH = 2;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RESET = '0;
  localparam int SYNC_W = DATA_W + 3 * LANES + 2;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } qpdbi_tx_state_t;

  // Count of asserted (logic one) bits in a lane
  function automatic logic [ONES_W-1:0] qpdbi_ones(
    input logic [LANE_W-1:0] v
  );
    logic [ONES_W-1:0] n;
    n = '0;
    for (int i = 0; i < LANE_W; i++) begin
      n = n + ONES_W'(v[i]);
    end
    return n;
  endfunction

  // Invert when more than half the lane would sit electrically low
  function automatic logic qpdbi_invert(input logic [LANE_W-1:0] d);
    return qpdbi_ones(d) > ONES_W'(LANE_HALF);
  endfunction

  // Electrical lane level to logical value, honouring the lane flag
  function automatic logic [LANE_W-1:0] qpdbi_decode(
    input logic [LANE_W-1:0] elec,
    input logic flag_n
  );
    return flag_n ? ~elec : elec;
  endfunction
endpackage

`timescale 1ns/100ps
module qpdbi_buf #(
  parameter int W = 256,
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  // Handshakes are combinational; full and empty come from the count
  assign in_ready = cnt_q != CW'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage, written at the write index
  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  // A full buffer with no drain must keep its count and its head word
  chk_buf_full_stall: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (cnt_q == CW'(DEPTH) && !out_ready) |=>
      (cnt_q == CW'(DEPTH)) && !in_ready && $stable(out_data)
  ) else $error("buffer took a word while full");
endmodule

// *** qpdbi_partner.sv ***
/*
  Far-side bus agent: records words the block drives and drives words
  for the block to receive.
  Assumes pins terminate high and the bus clock runs free.
*/
`timescale 1ns/100ps
module qpdbi_partner (
  // Clocks
  input wire logic core_clk,
  input wire logic bus_clk,
  // Bus as seen at the pins
  input wire logic oe,
  input wire logic [qpdbi_pkg::DATA_W-1:0] d_n,
  input wire logic [qpdbi_pkg::LANES-1:0] sp_n,
  input wire logic [qpdbi_pkg::LANES-1:0] sn_n,
  input wire logic [qpdbi_pkg::LANES-1:0] fl_n,
  input wire logic v_n,
  // Levels this agent drives
  output logic [qpdbi_pkg::DATA_W-1:0] drv_d_n,
  output logic [qpdbi_pkg::LANES-1:0] drv_sp_n,
  output logic [qpdbi_pkg::LANES-1:0] drv_sn_n,
  output logic [qpdbi_pkg::LANES-1:0] drv_fl_n,
  output logic drv_v_n
);
  import qpdbi_pkg::*;
  logic [WORD_W-1:0] got_w[$];
  logic [15:0] got_f[$];
  logic [WORD_W-1:0] cw;
  logic [15:0] cf;
  logic [LANES-1:0] pp, pn;
  logic pf, nf, done;
  int cnt[LANES];
  int bad;

  // Released lines sit at the termination level
  initial begin
    {drv_d_n, drv_sp_n, drv_sn_n, drv_fl_n, drv_v_n} = '1;
    pp = '1;
    pn = '1;
    bad = 0;
    foreach (cnt[n]) cnt[n] = 0;
  end

  // Lane n takes beats only from its own strobe pair; pins are looked at
  // mid-cycle, where the block's registered outputs have settled
  always @(negedge core_clk) begin
    done = 1'b1;
    for (int n = 0; n < LANES; n++) begin
      pf = pp[n] && !sp_n[n];
      nf = pn[n] && !sn_n[n];
      if (oe && (pf || nf)) begin
        if (pf == (cnt[n] % 2 != 0)) bad++;
        if (v_n !== 1'b0) bad++;
        cf[cnt[n] * LANES + n] = !fl_n[n];
        cw[(cnt[n] * LANES + n) * LANE_W +: LANE_W] =
          fl_n[n] ? ~d_n[n * LANE_W +: LANE_W] : d_n[n * LANE_W +: LANE_W];
        cnt[n]++;
      end
      done &= cnt[n] == BEATS;
    end
    if (done) begin
      got_w.push_back(cw);
      got_f.push_back(cf);
      foreach (cnt[n]) cnt[n] = 0;
    end
    pp = sp_n;
    pn = sn_n;
  end

  // One word per bus clock; inversion only where a lane would sit mostly low
  task automatic send(input logic [WORD_W-1:0] w, input logic [15:0] inv,
                      input logic last);
    logic [LANE_W-1:0] v;
    logic iv;
    @(posedge bus_clk);
    #4; // Keeps every data change clear of a core clock edge
    drv_v_n = 1'b0;
    for (int b = 0; b < BEATS; b++) begin
      if (b % 2) drv_sp_n = '1;
      else drv_sn_n = '1;
      for (int n = 0; n < LANES; n++) begin
        v = w[(b * LANES + n) * LANE_W +: LANE_W];
        iv = inv[b * LANES + n] && $countones(v) > LANE_HALF;
        drv_d_n[n * LANE_W +: LANE_W] = iv ? v : ~v;
        drv_fl_n[n] = !iv;
      end
      #25;
      if (b % 2) drv_sn_n = '0;
      else drv_sp_n = '0;
      if (b < BEATS - 1) #15;
    end
    // Keep data past the last fall; a following word takes over the lines
    if (last) begin
      #15;
      {drv_d_n, drv_sp_n, drv_sn_n, drv_fl_n, drv_v_n} = '1;
    end
  endtask
endmodule

// *** qpdbi_tb_top.sv ***
/*
  Self-checking bench: transmit then receive against a far-side agent.
  Assumes qpdbi_buf.sv and qpdbi_partner.sv are compiled first.
*/
`timescale 1ns/100ps
module qpdbi_tb_top;
  import qpdbi_pkg::*;
  logic core_clk, bus_clk, nrst, ce, tx_enable, tx_valid, full_seen, gap;
  logic [WORD_W-1:0] tx_word, w;
  logic [WORD_W-1:0] exp_q[$], rx_q[$];
  logic [31:0] seed, m;
  int fails, num_checks;
  wire logic tx_ready, rx_valid, d_oe, s_oe, f_oe, v_oe, v_o, p_v, v_w;
  wire logic [WORD_W-1:0] rx_word;
  wire logic [DATA_W-1:0] d_o, p_d, d_w;
  wire logic [LANES-1:0] sp_o, sn_o, f_o, p_sp, p_sn, p_f, sp_w, sn_w, f_w;

  // The block owns the wire while its enable is up; the far agent owns it otherwise
  assign d_w = d_oe ? d_o : p_d;
  assign sp_w = s_oe ? sp_o : p_sp;
  assign sn_w = s_oe ? sn_o : p_sn;
  assign f_w = f_oe ? f_o : p_f;
  assign v_w = v_oe ? v_o : p_v;

  qpdbi_top uut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .tx_enable(tx_enable), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_word(tx_word), .rx_valid(rx_valid), .rx_word(rx_word),
    .bus_clk(bus_clk), .data_in_n(d_w), .data_out_n(d_o), .data_oe(d_oe),
    .lane_strobe_pos_in_n(sp_w), .lane_strobe_pos_out_n(sp_o),
    .lane_strobe_neg_in_n(sn_w), .lane_strobe_neg_out_n(sn_o),
    .strobe_oe(s_oe), .lane_inversion_flags_in_n(f_w),
    .lane_inversion_flags_out_n(f_o), .flags_oe(f_oe),
    .data_valid_flag_in_n(v_w), .data_valid_flag_out_n(v_o),
    .valid_oe(v_oe));

  qpdbi_partner u_p (.core_clk(core_clk), .bus_clk(bus_clk), .oe(d_oe),
    .d_n(d_w), .sp_n(sp_w), .sn_n(sn_w), .fl_n(f_w), .v_n(v_w),
    .drv_d_n(p_d), .drv_sp_n(p_sp), .drv_sn_n(p_sn), .drv_fl_n(p_f),
    .drv_v_n(p_v));

  // Core clock 100 MHz; bus clock free running at an unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    bus_clk = 1'b0;
    #3;
    forever #(BUS_PERIOD_NS / 2) bus_clk = ~bus_clk;
  end

  // Fixed-seed xorshift
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Corner words first: empty, full, exactly half, one over half, mixed
  function automatic logic [WORD_W-1:0] pick(input int i);
    case (i)
      0: pick = '0;
      1: pick = '1;
      2: pick = {16{16'h00ff}};
      3: pick = {16{16'h01ff}};
      4: pick = {4{64'hfe00_00ff_0001_ffff}};
      default: for (int k = 0; k < 8; k++) pick[k * 32 +: 32] = rnd();
    endcase
  endfunction

  // A lane beat inverts when over half its lines would sit low
  function automatic logic [15:0] exp_flags(input logic [WORD_W-1:0] x);
    for (int k = 0; k < 16; k++)
      exp_flags[k] = $countones(x[k * LANE_W +: LANE_W]) > LANE_HALF;
  endfunction

  task automatic check(input string nm, input logic [WORD_W-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Offer a word until taken; the word is held while refused
  task automatic push(input logic [WORD_W-1:0] x);
    logic r;
    tx_valid <= 1'b1;
    tx_word <= x;
    for (int i = 0; i < 400; i++) begin
      @(negedge core_clk);
      r = tx_ready;
      if (r !== 1'b1) full_seen = 1'b1;
      @(posedge core_clk);
      if (r === 1'b1) return;
    end
    fails++;
    stop_test();
  endtask

  // Bounded wait for the far agent (0) or the bench (1) to hold n words
  task automatic wait_for(input int which, input int n);
    for (int i = 0; i < 5000; i++) begin
      @(posedge core_clk);
      if ((which ? rx_q.size() : u_p.got_w.size()) >= n) return;
    end
    fails++;
    stop_test();
  endtask

  // rx_valid stands one cycle; looked at mid-cycle, once it has settled
  always @(negedge core_clk) if (rx_valid === 1'b1) rx_q.push_back(rx_word);

  initial begin
    seed = 32'h0000_3e2b;
    fails = 0;
    num_checks = 0;
    full_seen = 1'b0;
    {nrst, ce, tx_enable, tx_valid, tx_word} = {1'b0, 1'b1, 258'h0};
    repeat (9) @(posedge core_clk);
    @(negedge core_clk);
    check("oe", {d_oe, s_oe, f_oe, v_oe, rx_valid}, 5'h0);
    check("idle", {d_o, sp_o, sn_o, f_o, v_o, tx_ready}, {78{1'b1}});
    @(posedge core_clk);
    nrst <= 1'b1;
    $display("test reset done");
    // Transmit, with the source pausing so some bus clocks stay idle
    tx_enable <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      w = pick(i);
      exp_q.push_back(w);
      push(w);
      if (rnd() % 4 == 0) begin
        tx_valid <= 1'b0;
        repeat (40) @(posedge core_clk);
      end
    end
    tx_valid <= 1'b0;
    wait_for(0, 12);
    repeat (30) @(posedge core_clk);
    foreach (exp_q[i]) begin
      check("tx word", u_p.got_w[i], exp_q[i]);
      check("tx flags", u_p.got_f[i], exp_flags(exp_q[i]));
    end
    @(negedge core_clk);
    check("tx idle", {d_o, v_o}, {65{1'b1}});
    check("tx oe", {d_oe, s_oe, f_oe, v_oe}, 4'hf);
    check("tx count", u_p.got_w.size(), 12);
    check("strobe order", u_p.bad, 0);
    check("buffer full", full_seen, 1'b1);
    check("rx while driving", rx_q.size(), 0);
    $display("test transmit done");
    // Receive with random inversion and idle bus clocks between words
    tx_enable <= 1'b0;
    exp_q = {};
    repeat (40) @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      w = pick(i);
      m = rnd();
      exp_q.push_back(w);
      gap = (m % 3 == 0) || i == 11;
      u_p.send(w, m[15:0], gap);
      if (gap) repeat (m[17:16] + 1) @(posedge bus_clk);
    end
    wait_for(1, 12);
    repeat (100) @(posedge core_clk);
    foreach (exp_q[i]) check("rx word", rx_q[i], exp_q[i]);
    check("rx count", rx_q.size(), 12);
    $display("test receive done");
    stop_test();
  end
endmodule

// *** qpdbi_top.sv ***
/*
  Data-phase logic of one bus agent: a quad-pumped, source-synchronous
  64-bit path in four 16-bit lanes, with per-lane inversion flags.
  Assumes the bus clock and all pins arrive asynchronously and are
  sampled by core_clk, which runs well above four beats per bus clock.
*/
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] All agents share one 64-bit data path wired identically.
// [RULE2] Driver asserts data valid per transfer; receivers trust only then.
// [RULE3] Four data beats are driven within one bus clock period.
// [RULE4] Beats latch on falling positive then negative strobe, alternating.
// [RULE5] Four 16-bit lanes, lane n uses strobe pair n and flag n.
// [RULE6] Receiver reads a lane as inverted while its flag is asserted.
// [RULE7] Flag asserted exactly when the lane is driven inverted.
// [RULE8] Invert a lane per beat when over half its bits sit low.
// [RULE9] One flag per lane driven alongside every beat.
// [RULE10] Data valid may drop for idle clocks; receivers skip them.
// [RULE11] All data, strobe, flag and valid pins are active low.
module qpdbi_top (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Transmit side: one word holds four beats, beat 0 in the low bits
  input wire logic tx_enable,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [qpdbi_pkg::WORD_W-1:0] tx_word,
  // Receive side: one-cycle pulse per assembled word
  output logic rx_valid,
  output logic [qpdbi_pkg::WORD_W-1:0] rx_word,
  // Bus clock pin
  input wire logic bus_clk,
  // Data pins
  input wire logic [qpdbi_pkg::DATA_W-1:0] data_in_n,
  output logic [qpdbi_pkg::DATA_W-1:0] data_out_n,
  output logic data_oe,
  // Lane strobes
  input wire logic [qpdbi_pkg::LANES-1:0] lane_strobe_pos_in_n,
  output logic [qpdbi_pkg::LANES-1:0] lane_strobe_pos_out_n,
  input wire logic [qpdbi_pkg::LANES-1:0] lane_strobe_neg_in_n,
  output logic [qpdbi_pkg::LANES-1:0] lane_strobe_neg_out_n,
  output logic strobe_oe,
  // Lane inversion flags
  input wire logic [qpdbi_pkg::LANES-1:0] lane_inversion_flags_in_n,
  output logic [qpdbi_pkg::LANES-1:0] lane_inversion_flags_out_n,
  output logic flags_oe,
  // Data valid
  input wire logic data_valid_flag_in_n,
  output logic data_valid_flag_out_n,
  output logic valid_oe
);
  import qpdbi_pkg::*;

  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [2*LANES:0] s3_q;
  logic [DATA_W-1:0] s_data;
  logic [LANES-1:0] s_pos;
  logic [LANES-1:0] s_neg;
  logic [LANES-1:0] s_flag;
  logic s_valid_n;
  logic s_bus;
  logic bus_rise;
  logic [LANES-1:0] pos_fall;
  logic [LANES-1:0] neg_fall;

  logic buf_valid;
  logic [WORD_W-1:0] buf_data;
  logic fire;
  qpdbi_tx_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WORD_W-1:0] tx_word_q;
  logic [BEAT_W-1:0] beat_idx;
  logic [CNT_W-1:0] phase;
  logic [DATA_W-1:0] beat_logic;
  logic [DATA_W-1:0] beat_enc;
  logic [LANES-1:0] beat_inv;
  logic [DATA_W-1:0] drv_beat_q;

  logic [BEAT_W-1:0] lane_cnt_q [LANES];
  logic [LANES-1:0] lane_done_q;
  logic [WORD_W-1:0] acc_q;
  logic [WORD_W-1:0] rx_word_q;
  logic rx_valid_q;

  // Two-flop synchroniser for every pin; s1 feeds s2 only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1_q <= '1;
      s2_q <= '1;
    end else if (ce) begin
      s1_q <= {bus_clk, data_valid_flag_in_n, lane_inversion_flags_in_n,
               lane_strobe_neg_in_n, lane_strobe_pos_in_n, data_in_n};
      s2_q <= s1_q;
    end
  end

  assign {s_bus, s_valid_n, s_flag, s_neg, s_pos, s_data} = s2_q;

  // Third stage on clock and strobes, for edge detection only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s3_q <= '1;
    end else if (ce) begin
      s3_q <= {s_bus, s_neg, s_pos};
    end
  end

  assign bus_rise = s_bus && !s3_q[2*LANES];
  assign pos_fall = s3_q[LANES-1:0] & ~s_pos;
  assign neg_fall = s3_q[2*LANES-1:LANES] & ~s_neg;

  // Two-entry word buffer; a full buffer stalls the source via tx_ready
  qpdbi_buf #(
    .W(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_word),
    .out_valid(buf_valid),
    .out_ready(fire),
    .out_data(buf_data)
  );

  // A bus clock carries a word only if one waits; otherwise it idles
  assign fire = bus_rise && tx_enable && buf_valid; // RULE10

  // Transmit sequencer: one bus clock per word, counted in core cycles
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= TX_IDLE;
      cnt_q <= CNT_RESET;
    end else if (ce) begin
      if (bus_rise) begin
        state_q <= fire ? TX_SEND : TX_IDLE;
        cnt_q <= CNT_RESET;
      end else if (state_q == TX_SEND) begin
        case (cnt_q)
          CNT_W'(BUS_CYC - 1): state_q <= TX_IDLE;
          default: cnt_q <= cnt_q + CNT_W'(1);
        endcase
      end
    end
  end

  // Word held for the whole bus clock while its beats go out
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_word_q <= '0;
    end else if (ce && fire) begin
      tx_word_q <= buf_data;
    end
  end

  // Beat selection and per-lane inversion decision
  assign beat_idx = BEAT_W'(cnt_q / CNT_W'(BEAT_CYC)); // RULE3
  assign phase = cnt_q % CNT_W'(BEAT_CYC);
  assign beat_logic = tx_word_q[beat_idx*DATA_W +: DATA_W];

  always_comb begin
    beat_inv = '0;
    beat_enc = '1;
    for (int l = 0; l < LANES; l++) begin
      beat_inv[l] = qpdbi_invert(beat_logic[l*LANE_W +: LANE_W]); // RULE8
      // Inverted lanes go out at logical level, others active low
      beat_enc[l*LANE_W +: LANE_W] = beat_inv[l] ?
        beat_logic[l*LANE_W +: LANE_W] :
        ~beat_logic[l*LANE_W +: LANE_W]; // RULE11
    end
  end

  // Registered pin drive; every signal lags the sequencer by one cycle
  // so data, flags and strobes stay aligned with each other.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      data_oe <= 1'b0;
      strobe_oe <= 1'b0;
      flags_oe <= 1'b0;
      valid_oe <= 1'b0;
      data_out_n <= '1;
      lane_inversion_flags_out_n <= '1;
      lane_strobe_pos_out_n <= '1;
      lane_strobe_neg_out_n <= '1;
      data_valid_flag_out_n <= IDLE_LEVEL;
      drv_beat_q <= '0;
    end else if (ce) begin
      data_oe <= tx_enable; // RULE1
      strobe_oe <= tx_enable;
      flags_oe <= tx_enable; // RULE9
      valid_oe <= tx_enable;
      if (state_q == TX_SEND) begin
        data_out_n <= beat_enc; // RULE5
        lane_inversion_flags_out_n <= ~beat_inv; // RULE7
        data_valid_flag_out_n <= 1'b0; // RULE2
        // Strobe falls mid-beat: positive on even, negative on odd
        lane_strobe_pos_out_n <= (!beat_idx[0] &&
          phase >= CNT_W'(STROBE_PHASE)) ? '0 : '1; // RULE4
        lane_strobe_neg_out_n <= (beat_idx[0] &&
          phase >= CNT_W'(STROBE_PHASE)) ? '0 : '1; // RULE4
        drv_beat_q <= beat_logic;
      end else begin
        data_out_n <= '1;
        lane_inversion_flags_out_n <= '1;
        data_valid_flag_out_n <= IDLE_LEVEL;
        lane_strobe_pos_out_n <= '1;
        lane_strobe_neg_out_n <= '1;
      end
    end
  end

  // Receive lanes: each lane steps through its four beats on its own
  // strobe pair. Lanes are gathered independently because each pair
  // may skew against the others; a dropped valid restarts them all.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lane_done_q <= '0;
      acc_q <= '0;
      for (int l = 0; l < LANES; l++) begin
        lane_cnt_q[l] <= '0;
      end
    end else if (ce) begin
      if (&lane_done_q) begin
        lane_done_q <= '0;
      end
      for (int l = 0; l < LANES; l++) begin
        if (tx_enable || s_valid_n) begin
          lane_cnt_q[l] <= '0; // RULE10
          lane_done_q[l] <= 1'b0;
        end else if ((!lane_cnt_q[l][0] && pos_fall[l]) ||
                     (lane_cnt_q[l][0] && neg_fall[l])) begin // RULE4
          acc_q[(int'(lane_cnt_q[l])*LANES + l)*LANE_W +: LANE_W] <=
            qpdbi_decode(s_data[l*LANE_W +: LANE_W], s_flag[l]); // RULE6
          lane_cnt_q[l] <= lane_cnt_q[l] + BEAT_W'(1);
          if (lane_cnt_q[l] == BEAT_W'(BEATS - 1)) begin
            lane_done_q[l] <= 1'b1;
          end
        end
      end
    end
  end

  // Hand the assembled word over once every lane has all four beats
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_valid_q <= 1'b0;
      rx_word_q <= '0;
    end else if (ce) begin
      rx_valid_q <= &lane_done_q; // RULE2
      if (&lane_done_q) begin
        rx_word_q <= acc_q;
      end
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_word = rx_word_q;

  // Per-lane checks on the driven encoding
  for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
    chk_flag_majority: assert property ( // RULE8
      @(posedge core_clk) disable iff (!nrst)
      !lane_inversion_flags_out_n[g] |->
        qpdbi_ones(data_out_n[g*LANE_W +: LANE_W]) > ONES_W'(LANE_HALF)
    ) else $error("lane inverted without a low majority");
    chk_flag_exact: assert property ( // RULE7
      @(posedge core_clk) disable iff (!nrst)
      (!data_valid_flag_out_n && lane_inversion_flags_out_n[g]) |->
        qpdbi_ones(data_out_n[g*LANE_W +: LANE_W]) >= ONES_W'(LANE_HALF)
    ) else $error("lane left plain with a low majority");
    chk_strobe_overlap: assert property ( // RULE4
      @(posedge core_clk) disable iff (!nrst)
      !(!lane_strobe_pos_out_n[g] && !lane_strobe_neg_out_n[g])
    ) else $error("both strobes of a lane low together");
  end

  chk_beat_decode: assert property ( // RULE11
    @(posedge core_clk) disable iff (!nrst)
    !data_valid_flag_out_n |-> (qpdbi_decode(data_out_n[LANE_W-1:0],
      lane_inversion_flags_out_n[0]) == drv_beat_q[LANE_W-1:0]) &&
      (qpdbi_decode(data_out_n[DATA_W-1 -: LANE_W],
      lane_inversion_flags_out_n[LANES-1]) == drv_beat_q[DATA_W-1 -: LANE_W])
  ) else $error("driven lane does not decode to its beat");
  chk_quad_beats: assert property ( // RULE3
    @(posedge core_clk) disable iff (!nrst || !ce)
    $fell(data_valid_flag_out_n) |-> ##2 $fell(lane_strobe_pos_out_n[0])
      ##4 $fell(lane_strobe_neg_out_n[0]) ##4 $fell(lane_strobe_pos_out_n[0])
      ##4 $fell(lane_strobe_neg_out_n[0])
  ) else $error("four beats not placed within one bus clock");
  chk_valid_span: assert property ( // RULE2
    @(posedge core_clk) disable iff (!nrst || !ce)
    $fell(data_valid_flag_out_n) |-> !data_valid_flag_out_n[*8]
  ) else $error("data valid dropped inside a bus clock");
  chk_idle_quiet: assert property ( // RULE10
    @(posedge core_clk) disable iff (!nrst)
    data_valid_flag_out_n |-> (&lane_strobe_pos_out_n) &&
      (&lane_strobe_neg_out_n) && (&lane_inversion_flags_out_n)
  ) else $error("strobe or flag active in an idle clock");
  chk_enable_group: assert property ( // RULE9
    @(posedge core_clk) disable iff (!nrst)
    data_oe |-> (flags_oe && strobe_oe && valid_oe)
  ) else $error("flags not driven together with data");
  chk_rx_skip: assert property ( // RULE10
    @(posedge core_clk) disable iff (!nrst || !ce)
    s_valid_n |=> (lane_cnt_q[0] == '0) && (lane_done_q == '0)
  ) else $error("receiver kept beats across an idle clock");
  chk_rx_pulse: assert property ( // RULE2
    @(posedge core_clk) disable iff (!nrst || !ce)
    rx_valid |=> !rx_valid
  ) else $error("receive pulse longer than one cycle");
endmodule
